// file: bench/pchr_tb.sv
// Purpose: Self-checking bench of the configuration header bank
// Assumes: Short self test of 10 cycles; a second bank flips the options
// Notes:   Register port master changes signals right after rising edges
`timescale 1ns/100ps

`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("wrong value at %0t: got %h expected %h", \
                 $time, got, exp); \
    end \
end

module testbench;
    import pchr_pkg::*;
    logic       clk, reset_n, wr_en, rd_en, rd_valid, running;
    logic       master_parity_detect, parity_line_seen, irq, pre, running2;
    pchr_addr_t addr;
    pchr_data_t wr_data, rd_data, rd_data2;
    pchr_code_t code, fail_code;
    logic [63:0] mem_base;
    int         miscompares, comparisons, cycles, n;
    localparam logic [7:0] FA [0:8] = '{8'h20, 8'h24, 8'h30, 8'h34,
        8'h38, 8'h18, 8'hd0, 8'hf8, 8'h60};
    localparam pchr_data_t FV [0:8] = '{32'h5a, 32'h00010802, 32'h0,
        32'h0, 32'h0, 32'h10, 32'hf8, 32'h0001, 32'h0};

    pchr_regs #(.REVISION(8'h5a), .SELF_TEST_CYCLES(10)) dut (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .rd_valid(rd_valid), .master_parity_detect(master_parity_detect),
        .parity_line_seen(parity_line_seen), .interrupt_asserted(irq),
        .self_test_code(code), .parity_response_enable(pre),
        .self_test_running(running), .mem_base(mem_base));

    pchr_test_engine engine (.clk(clk), .reset_n(reset_n),
        .running(running), .fail_code(fail_code), .code(code));

    // Second bank with every option flipped: parallel bus, no self test
    pchr_regs #(.REVISION(8'h5a), .FAST_B2B(1'b1), .HIGH_SPEED(1'b1),
        .MULTI_FUNCTION(1'b1), .SELF_TEST_PRESENT(1'b0),
        .SERIAL_LINK(1'b0), .BAR_RO_BITS(16), .SELF_TEST_CYCLES(10))
        dut_alt (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data2), .rd_valid(),
        .master_parity_detect(master_parity_detect),
        .parity_line_seen(parity_line_seen), .interrupt_asserted(irq),
        .self_test_code(code), .parity_response_enable(),
        .self_test_running(running2), .mem_base());

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****************************************
    // Bus cycles
    // ****************************************
    task automatic wr(input logic [7:0] a, input pchr_data_t d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input pchr_data_t exp);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data, exp)
    endtask : rd

    task automatic do_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        #1;
    endtask : do_reset

    task automatic pulse(input bit on_line);
        @(posedge clk);
        if (on_line) parity_line_seen <= 1'b1;
        else master_parity_detect <= 1'b1;
        @(posedge clk);
        parity_line_seen     <= 1'b0;
        master_parity_detect <= 1'b0;
    endtask : pulse

    task automatic wait_done;
        n = 0;
        while (running === 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_done

    // ****************************************
    // Scenarios
    // ****************************************
    // Fixed fields read the same before and after a write of all ones
    task automatic t_fixed;
        for (int i = 0; i < 9; i++) begin
            rd(FA[i], FV[i]);
            wr(FA[i], 32'hffffffff);
            rd(FA[i], FV[i]);
        end
    endtask : t_fixed

    task automatic t_status;
        @(posedge clk);
        irq <= 1'b1;
        rd(8'h18, 32'h18);
        @(posedge clk);
        irq <= 1'b0;
        rd(8'h18, 32'h10);
        pulse(1'b0);
        rd(8'h18, 32'h10);
        wr(8'h10, 32'h40);
        `CHK(pre, 1'b1)
        pulse(1'b0);
        rd(8'h18, 32'h110);
        wr(8'h18, 32'h100);
        rd(8'h18, 32'h10);
        pulse(1'b1);
        wr(8'h18, 32'h0);
        rd(8'h18, 32'h110);
        wr(8'h18, 32'h100);
        rd(8'h18, 32'h10);
    endtask : t_status

    task automatic t_base;
        wr(8'h40, 32'hffffffff);
        `CHK(mem_base[31:0], 32'hffffc000)
        rd(8'h40, 32'hffffc004);
        wr(8'h40, 32'h00003fff);
        rd(8'h40, 32'h00000004);
        wr(8'h50, 32'h12345678);
        rd(8'h50, 32'h12345678);
        `CHK(mem_base[63:32], 32'h12345678)
    endtask : t_base

    // Passing run, failing run, then a reset in the middle of a run
    task automatic t_selftest;
        rd(8'h3c, 32'h80);
        for (int k = 0; k < 2; k++) begin
            fail_code <= k ? 4'h5 : 4'h0;
            wr(8'h3c, 32'h40);
            `CHK(running, 1'b1)
            wait_done;
            `CHK(n, 10)
            rd(8'h3c, k ? 32'h85 : 32'h80);
        end
        wr(8'h3c, 32'h40);
        repeat (3) @(posedge clk);
        do_reset;
        `CHK(running, 1'b0)
        rd(8'h3c, 32'h80);
    endtask : t_selftest

    // Second bank: option bits, writable latency, wider read-only base
    task automatic t_alt;
        rd(8'h18, 32'h10);
        `CHK(rd_data2, 32'hb0)
        rd(8'h38, 32'h0);
        `CHK(rd_data2, 32'h80)
        wr(8'h3c, 32'hff);
        `CHK(running2, 1'b0)
        rd(8'h3c, 32'hc0);
        `CHK(rd_data2, 32'h0)
        wr(8'h34, 32'h5c);
        rd(8'h34, 32'h0);
        `CHK(rd_data2, 32'h5c)
        wr(8'h40, 32'hffffffff);
        rd(8'h40, 32'hffffc004);
        `CHK(rd_data2, 32'hffff0004)
        wait_done;
    endtask : t_alt

    task automatic close_out;
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // Whole run needs well under 1000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        reset_n = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 32'h0;
        irq = 1'b0;
        master_parity_detect = 1'b0;
        parity_line_seen = 1'b0;
        fail_code = 4'h0;
        do_reset;
        t_fixed;
        t_status;
        t_base;
        t_selftest;
        t_alt;
        close_out();
    end
endmodule : testbench

// file: bench/pchr_test_engine.sv
// Purpose: Self-test engine model that feeds the result code to the bank
// Assumes: Result is only meaningful while the bank reports a running test
// Notes:   Outside a test the code toggles so that a stale sample shows up
`timescale 1ns/100ps

module pchr_test_engine
    import pchr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        running,
    input  wire pchr_code_t  fail_code,
    output pchr_code_t       code
);
    // Idle pattern flips every cycle: a result latched early would differ
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            code <= 4'ha;
        end else if (running) begin
            code <= fail_code;
        end else begin
            code <= ~code;
        end
    end
endmodule : pchr_test_engine

// file: logic/pchr_params.svh
// Purpose: Offsets, field positions and reset values of the header bank
// Assumes: Included by its bare name
// Notes:   Offsets are register indices; byte address is four times each
`ifndef PCHR_PARAMS_SVH
`define PCHR_PARAMS_SVH
// ****************************************
// Register indices
// ****************************************
`define PCHR_IDX_CONTROL      6'h04
`define PCHR_IDX_STATUS       6'h06
`define PCHR_IDX_REVISION     6'h08
`define PCHR_IDX_CLASS        6'h09
`define PCHR_IDX_CACHE_LINE   6'h0c
`define PCHR_IDX_LATENCY      6'h0d
`define PCHR_IDX_HEADER       6'h0e
`define PCHR_IDX_SELF_TEST    6'h0f
`define PCHR_IDX_BASE_LOW     6'h10
`define PCHR_IDX_BASE_HIGH    6'h14
`define PCHR_IDX_CAP_PTR      6'h34
`define PCHR_IDX_PM_CAP       6'h3e
// ****************************************
// Field positions and fixed values
// ****************************************
`define PCHR_CTRL_PARITY_BIT  6
`define PCHR_STS_MPE_BIT      8
`define PCHR_STS_FB2B_BIT     7
`define PCHR_STS_HS_BIT       5
`define PCHR_STS_CAPL_BIT     4
`define PCHR_STS_IRQ_BIT      3
`define PCHR_ST_CAP_BIT       7
`define PCHR_ST_START_BIT     6
`define PCHR_BASE_CLASS       8'h01
`define PCHR_SUB_CLASS        8'h08
`define PCHR_PROG_IF          8'h02
`define PCHR_ZERO_BYTE        8'h00
`define PCHR_HEADER_LAYOUT    7'h00
`define PCHR_BAR_TYPE         2'b10
`define PCHR_BAR_LOW_RO       14
`define PCHR_PM_CAP_ID        8'h01
`define PCHR_PM_NEXT          8'h00
// ****************************************
// Timing
// ****************************************
`define PCHR_CLK_NS           40
`define PCHR_SELF_TEST_NS     2000
`define PCHR_SELF_TEST_CYC \
    ((`PCHR_SELF_TEST_NS + `PCHR_CLK_NS - 1) / `PCHR_CLK_NS)
`endif

// file: logic/pchr_pkg.sv
// Purpose: Types shared by the header bank
// Assumes: Nothing
// Notes:   Constants live in pchr_params.svh
package pchr_pkg;
    typedef logic [7:0]  pchr_addr_t;
    typedef logic [31:0] pchr_data_t;
    typedef logic [3:0]  pchr_code_t;
    typedef enum logic [0:0] {
        PCHR_ST_IDLE,
        PCHR_ST_RUN
    } pchr_test_state_t;
endpackage : pchr_pkg

// file: logic/pchr_regs.sv
// Purpose: Configuration header bank of a storage controller
// Assumes: Plain register port, read data one cycle after read strobe
// Notes:   Byte-wide fields sit in the low bits of their word
//
// Functional notes
// - Master parity flag set on parity event while response enabled; W1C.
// - Status bit 4 reads 1: capability list present.
// - Capability list holds at least the power management entry.
// - Status bit 3 mirrors the interrupt output level.
// - Status bits 7 and 5 report chosen back-to-back and speed ability.
// - Read-only 8-bit hardware revision field.
// - Class code reads 01h, 08h, 02h.
// - Cache line size reads 00h, read-only.
// - Latency timer 00h read-only on serial link, else writable.
// - Header layout 00h, bit 7 a chosen multi-function flag.
// - Without self test the register reads 00h, read-only.
// - Writing 1 to bit 6 starts self test; cleared when done.
// - Bits 3:0 hold self-test result, zero means pass.
// - Bit 7 of self-test register shows self test exists.
// - Base bits 31:14 writable; more low bits may be read-only.
// - Base bits 13:4 and bit 3 read zero.
// - Base bits 2:1 read 10: 64-bit placement.
// - Base bit 0 reads 0: memory space.
// - Upper base address register writable at index 14h.
// - Parity response enable is bit 6 of the command register.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`include "pchr_params.svh"

module pchr_regs #(
    parameter logic [7:0] REVISION          = 8'h01, // Arbitrary value
    parameter bit         FAST_B2B          = 1'b0,
    parameter bit         HIGH_SPEED        = 1'b0,
    parameter bit         MULTI_FUNCTION    = 1'b0,
    parameter bit         SELF_TEST_PRESENT = 1'b1,
    parameter bit         SERIAL_LINK       = 1'b1,
    parameter int         BAR_RO_BITS       = `PCHR_BAR_LOW_RO,
    parameter int         SELF_TEST_CYCLES  = `PCHR_SELF_TEST_CYC
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire pchr_pkg::pchr_addr_t addr,
    input  wire pchr_pkg::pchr_data_t wr_data,
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    output pchr_pkg::pchr_data_t    rd_data,
    output logic                    rd_valid,
    input  wire logic               master_parity_detect,
    input  wire logic               parity_line_seen,
    input  wire logic               interrupt_asserted,
    input  wire pchr_pkg::pchr_code_t self_test_code,
    output logic                    parity_response_enable,
    output logic                    self_test_running,
    output logic [63:0]             mem_base
);
    import pchr_pkg::*;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic hit(input pchr_addr_t a, input logic [5:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    localparam pchr_data_t BAR_MASK =
        ~((32'h1 << BAR_RO_BITS) - 32'h1);
    localparam int CNT_W = $clog2(SELF_TEST_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST =
        CNT_W'(SELF_TEST_CYCLES - 1);

    logic               master_parity_error_flag;
    logic [7:0]         master_latency_timer;
    logic [31:0]        memory_base_low;
    logic [31:0]        memory_base_high;
    pchr_code_t         self_test_result;
    pchr_test_state_t   test_state;
    logic [CNT_W-1:0]   test_count;
    logic               parity_event;
    logic               wr_status;
    logic               wr_self_test;
    logic               test_start;
    logic               test_done;
    logic [15:0]        device_status;
    logic [7:0]         self_test_control;
    logic [7:0]         header_type;
    pchr_data_t         next_rd_data;

    assign wr_status    = wr_en && hit(addr, `PCHR_IDX_STATUS);
    assign wr_self_test = wr_en && hit(addr, `PCHR_IDX_SELF_TEST);

    // ****************************************
    // Command bit: parity response enable
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            parity_response_enable <= 1'b0;
        end else if (wr_en && hit(addr, `PCHR_IDX_CONTROL)) begin
            parity_response_enable <= wr_data[`PCHR_CTRL_PARITY_BIT];
        end
    end

    // ****************************************
    // Master parity flag
    // ****************************************
    // An event in the clear cycle wins, so no parity report is lost
    assign parity_event = parity_response_enable &&
                          (master_parity_detect || parity_line_seen);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            master_parity_error_flag <= 1'b0;
        end else if (parity_event) begin
            master_parity_error_flag <= 1'b1;
        end else if (wr_status && wr_data[`PCHR_STS_MPE_BIT]) begin
            master_parity_error_flag <= 1'b0;
        end
    end

    // ****************************************
    // Status word
    // ****************************************
    // Bits above 8 belong to other status logic and read zero here
    always_comb begin
        device_status = 16'h0000;
        device_status[`PCHR_STS_MPE_BIT]  = master_parity_error_flag;
        device_status[`PCHR_STS_FB2B_BIT] = FAST_B2B;
        device_status[`PCHR_STS_HS_BIT]   = HIGH_SPEED;
        device_status[`PCHR_STS_CAPL_BIT] = 1'b1;
        device_status[`PCHR_STS_IRQ_BIT]  = interrupt_asserted;
    end

    // ****************************************
    // Latency timer
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            master_latency_timer <= `PCHR_ZERO_BYTE;
        end else if (!SERIAL_LINK && wr_en &&
                     hit(addr, `PCHR_IDX_LATENCY)) begin
            master_latency_timer <= wr_data[7:0];
        end
    end

    assign header_type = {MULTI_FUNCTION, `PCHR_HEADER_LAYOUT};

    // ****************************************
    // Self test sequencer
    // ****************************************
    // Writes while a test runs are ignored; only reset aborts a test
    assign test_start = SELF_TEST_PRESENT && wr_self_test &&
                        wr_data[`PCHR_ST_START_BIT] &&
                        (test_state == PCHR_ST_IDLE);
    assign test_done  = (test_state == PCHR_ST_RUN) &&
                        (test_count == CNT_LAST);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            test_state <= PCHR_ST_IDLE;
            test_count <= '0;
        end else begin
            case (test_state)
                PCHR_ST_IDLE: begin
                    test_count <= '0;
                    if (test_start) begin
                        test_state <= PCHR_ST_RUN;
                    end
                end
                PCHR_ST_RUN: begin
                    test_count <= test_count + 1'b1;
                    if (test_done) begin
                        test_state <= PCHR_ST_IDLE;
                    end
                end
                default: begin
                    test_state <= PCHR_ST_IDLE;
                    test_count <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            self_test_result <= '0;
        end else if (test_done) begin
            self_test_result <= self_test_code;
        end
    end

    assign self_test_running = (test_state == PCHR_ST_RUN);

    always_comb begin
        if (SELF_TEST_PRESENT) begin
            self_test_control = {1'b1, self_test_running, 2'b00,
                                 self_test_result};
        end else begin
            self_test_control = `PCHR_ZERO_BYTE;
        end
    end

    // ****************************************
    // Memory base address pair
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            memory_base_low <= 32'h0000_0000;
        end else if (wr_en && hit(addr, `PCHR_IDX_BASE_LOW)) begin
            memory_base_low <= wr_data & BAR_MASK;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            memory_base_high <= 32'h0000_0000;
        end else if (wr_en && hit(addr, `PCHR_IDX_BASE_HIGH)) begin
            memory_base_high <= wr_data;
        end
    end

    assign mem_base = {memory_base_high, memory_base_low};

    // ****************************************
    // Read port
    // ****************************************
    // Every other field is read-only, so no write path reaches it
    always_comb begin
        next_rd_data = 32'h0000_0000;
        if (hit(addr, `PCHR_IDX_CONTROL)) begin
            next_rd_data[`PCHR_CTRL_PARITY_BIT] = parity_response_enable;
        end else if (hit(addr, `PCHR_IDX_STATUS)) begin
            next_rd_data[15:0] = device_status;
        end else if (hit(addr, `PCHR_IDX_REVISION)) begin
            next_rd_data[7:0] = REVISION;
        end else if (hit(addr, `PCHR_IDX_CLASS)) begin
            next_rd_data[23:0] = {`PCHR_BASE_CLASS, `PCHR_SUB_CLASS,
                                  `PCHR_PROG_IF};
        end else if (hit(addr, `PCHR_IDX_CACHE_LINE)) begin
            next_rd_data[7:0] = `PCHR_ZERO_BYTE;
        end else if (hit(addr, `PCHR_IDX_LATENCY)) begin
            next_rd_data[7:0] = master_latency_timer;
        end else if (hit(addr, `PCHR_IDX_HEADER)) begin
            next_rd_data[7:0] = header_type;
        end else if (hit(addr, `PCHR_IDX_SELF_TEST)) begin
            next_rd_data[7:0] = self_test_control;
        end else if (hit(addr, `PCHR_IDX_BASE_LOW)) begin
            // Bits 13:3 and 0 stay zero, type field says 64-bit
            next_rd_data = memory_base_low;
            next_rd_data[2:1] = `PCHR_BAR_TYPE;
        end else if (hit(addr, `PCHR_IDX_BASE_HIGH)) begin
            next_rd_data = memory_base_high;
        end else if (hit(addr, `PCHR_IDX_CAP_PTR)) begin
            next_rd_data[7:0] = {`PCHR_IDX_PM_CAP, 2'b00};
        end else if (hit(addr, `PCHR_IDX_PM_CAP)) begin
            next_rd_data[15:0] = {`PCHR_PM_NEXT, `PCHR_PM_CAP_ID};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data  <= 32'h0000_0000;
            rd_valid <= 1'b0;
        end else begin
            rd_data  <= rd_en ? next_rd_data : 32'h0000_0000;
            rd_valid <= rd_en;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    localparam int ST_LIMIT = SELF_TEST_CYCLES + 1;

    sequence s_rd(logic [5:0] idx);
        rd_en && hit(addr, idx);
    endsequence

    sequence s_test_start;
        SELF_TEST_PRESENT && wr_self_test && wr_data[`PCHR_ST_START_BIT] &&
        !self_test_running;
    endsequence

    a_parity_set: assert property (
        parity_event |=> master_parity_error_flag)
        else $error("parity flag not set");

    a_parity_gated: assert property (
        (!master_parity_error_flag && !parity_response_enable)
        |=> !master_parity_error_flag)
        else $error("parity flag set while response disabled");

    a_parity_clear: assert property (
        (wr_status && wr_data[`PCHR_STS_MPE_BIT] && !parity_event)
        |=> !master_parity_error_flag)
        else $error("parity flag not cleared");

    a_status_read: assert property (
        s_rd(`PCHR_IDX_STATUS) |=> rd_data[`PCHR_STS_CAPL_BIT] &&
        rd_data[`PCHR_STS_IRQ_BIT] == $past(interrupt_asserted) &&
        rd_data[`PCHR_STS_MPE_BIT] == $past(master_parity_error_flag))
        else $error("status read wrong");

    a_class_read: assert property (
        s_rd(`PCHR_IDX_CLASS) |=> rd_data == 32'h0001_0802)
        else $error("class code wrong");

    a_fixed_zero: assert property (
        s_rd(`PCHR_IDX_CACHE_LINE) |=> rd_data == 32'h0000_0000)
        else $error("cache line size not zero");

    a_bar_low_read: assert property (
        s_rd(`PCHR_IDX_BASE_LOW) |=> rd_data[13:0] == 14'h0004 &&
        rd_data[31:14] == $past(memory_base_low[31:14]))
        else $error("base low read wrong");

    a_bar_low_write: assert property (
        (wr_en && hit(addr, `PCHR_IDX_BASE_LOW))
        |=> memory_base_low == ($past(wr_data) & BAR_MASK))
        else $error("base low write lost");

    a_test_runs: assert property (
        s_test_start |=> self_test_running[*8])
        else $error("self test stopped early");

    a_test_ends: assert property (
        s_test_start |-> ##[1:ST_LIMIT] !self_test_running)
        else $error("self test never finished");

    a_test_result: assert property (
        $fell(self_test_running) |-> self_test_result ==
        $past(self_test_code))
        else $error("self test result not captured");

    a_read_idle: assert property (
        !rd_en |=> rd_data == 32'h0000_0000 && !rd_valid)
        else $error("read data outside read slot");

    a_read_answer: assert property (
        rd_en |=> rd_valid)
        else $error("read strobe not answered");

    a_ctrl_write: assert property (
        (wr_en && hit(addr, `PCHR_IDX_CONTROL))
        |=> parity_response_enable == $past(wr_data[`PCHR_CTRL_PARITY_BIT]))
        else $error("parity response enable not written");

    a_bar_high_write: assert property (
        (wr_en && hit(addr, `PCHR_IDX_BASE_HIGH))
        |=> memory_base_high == $past(wr_data))
        else $error("upper base write lost");

    a_latency_read: assert property (
        s_rd(`PCHR_IDX_LATENCY) |=>
        (!SERIAL_LINK || rd_data == 32'h0000_0000))
        else $error("latency timer not zero on serial link");

    a_header_read: assert property (
        s_rd(`PCHR_IDX_HEADER) |=>
        rd_data == {24'h00_0000, MULTI_FUNCTION, `PCHR_HEADER_LAYOUT})
        else $error("header type wrong");

    a_test_absent: assert property (
        s_rd(`PCHR_IDX_SELF_TEST) |=>
        (SELF_TEST_PRESENT || rd_data == 32'h0000_0000))
        else $error("absent self test not zero");

    a_cap_pointer: assert property (
        s_rd(`PCHR_IDX_CAP_PTR) |=>
        rd_data == {24'h00_0000, `PCHR_IDX_PM_CAP, 2'b00})
        else $error("capability pointer wrong");

endmodule : pchr_regs
